//--- rtl/hdc_pkg.sv
// Purpose: Shared constants and types of the haptic drive control register bank
// Assumes: APB with 32-bit data, 250 MHz pclk
// Notes:   Register byte address is four times the register index
package hdc_pkg;

	// Register indices and byte addresses
	localparam logic [7:0] DRIVE_CONTROL_ONE_IDX  = 8'h1B;
	localparam logic [7:0] DRIVE_CONTROL_TWO_IDX  = 8'h1C;
	localparam logic [7:0] DRIVE_CONTROL_ONE_ADDR = 8'h6C;
	localparam logic [7:0] DRIVE_CONTROL_TWO_ADDR = 8'h70;
	localparam int         ADDR_W                 = 8;
	localparam int         DATA_W                 = 32;

	// Field positions, first control register
	localparam int BOOST_BIT    = 7;
	localparam int RSVD_BIT     = 6;
	localparam int BIAS_BIT     = 5;
	localparam int DTIME_LSB    = 0;
	localparam int DTIME_W      = 5;
	// Field positions, second control register
	localparam int DIR_BIT      = 7;
	localparam int BRAKE_BIT    = 6;
	localparam int SAMPLE_LSB   = 4;
	localparam int BLANK_LSB    = 2;
	localparam int SETTLE_LSB   = 0;

	// Values after reset, and the writable bit mask of the first register
	localparam logic [7:0] CTRL_ONE_RESET = 8'h93;
	localparam logic [7:0] CTRL_TWO_RESET = 8'hF5;
	localparam logic [7:0] CTRL_ONE_MASK  = 8'hBF;

	// Drive time arithmetic, times in microseconds
	localparam int CLK_MHZ      = 250;
	localparam int LRA_STEP_US  = 100;
	localparam int LRA_BASE_US  = 500;
	localparam int ERM_STEP_US  = 200;
	localparam int ERM_BASE_US  = 1000;
	localparam int LRA_STEP_CYC = LRA_STEP_US * CLK_MHZ;
	localparam int LRA_BASE_CYC = LRA_BASE_US * CLK_MHZ;
	localparam int ERM_STEP_CYC = ERM_STEP_US * CLK_MHZ;
	localparam int ERM_BASE_CYC = ERM_BASE_US * CLK_MHZ;

	// Amplitude
	localparam int SAMPLE_W = 8;
	localparam int LEVEL_W  = 9;

	typedef logic [DTIME_W-1:0]  hdc_code_t;
	typedef logic [SAMPLE_W-1:0] hdc_sample_t;
	typedef logic [LEVEL_W-1:0]  hdc_level_t;

endpackage : hdc_pkg

//--- rtl/hdc_timer_if.sv
// Purpose: Carrier between the register bank and the drive period timer
// Assumes: Single pclk domain
// Notes:   Tick is a one-cycle pulse per elapsed period
`timescale 1ns/100ps
interface hdc_timer_if;
	import hdc_pkg::*;
	hdc_code_t code;     // Current drive time code
	logic      lra_mode; // High for linear resonant timing
	logic      run;      // Timer running
	logic      tick;     // Period elapsed

	modport ctrl  (output code, output lra_mode, output run, input tick);
	modport timer (input code, input lra_mode, input run, output tick);
endinterface : hdc_timer_if

//--- rtl/hdc_drive_timer.sv
// Purpose: Counts the LRA or ERM drive time period from a 5-bit code
// Assumes: Step and base counts given in pclk cycles
// Notes:   Period is base plus code times step
`timescale 1ns/100ps
module hdc_drive_timer #(
	parameter int LRA_STEP = hdc_pkg::LRA_STEP_CYC, // Cycles per LRA step
	parameter int LRA_BASE = hdc_pkg::LRA_BASE_CYC, // LRA base cycles
	parameter int ERM_STEP = hdc_pkg::ERM_STEP_CYC, // Cycles per ERM step
	parameter int ERM_BASE = hdc_pkg::ERM_BASE_CYC  // ERM base cycles
) (
	input  wire logic   pclk,    // Clock
	input  wire logic   presetn, // Async reset, active low
	hdc_timer_if.timer  tif      // Code in, tick out
);
	import hdc_pkg::*;

	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} hdc_tmr_state_t;

	hdc_tmr_state_t r;
	hdc_tmr_state_t next_r;
	logic [31:0]    period;

	// Period length from code and mode
	always_comb begin
		if (tif.lra_mode) begin
			period = 32'(LRA_BASE) + 32'(tif.code) * 32'(LRA_STEP);
		end else begin
			period = 32'(ERM_BASE) + 32'(tif.code) * 32'(ERM_STEP);
		end
	end

	// Count and wrap
	always_comb begin
		next_r      = r;
		next_r.tick = 1'b0;
		if (!tif.run) begin
			next_r.cnt = 32'h0;
		end else if (r.cnt >= period - 32'h1) begin
			next_r.cnt  = 32'h0;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 32'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tif.tick = r.tick;

endmodule : hdc_drive_timer

//--- rtl/hdc_regs.sv
// Purpose: Drive control register bank of a haptic playback engine, with APB access
// Assumes: APB3 master; inputs synchronous to pclk
// Notes:   Answers every access with one access cycle, no wait state
`timescale 1ns/100ps

module hdc_regs #(
	parameter int LRA_STEP_CYCLES = hdc_pkg::LRA_STEP_CYC, // 0.1 ms in cycles
	parameter int LRA_BASE_CYCLES = hdc_pkg::LRA_BASE_CYC, // 0.5 ms in cycles
	parameter int ERM_STEP_CYCLES = hdc_pkg::ERM_STEP_CYC, // 0.2 ms in cycles
	parameter int ERM_BASE_CYCLES = hdc_pkg::ERM_BASE_CYC  // 1 ms in cycles
) (
	input  wire logic                       pclk,                  // Clock
	input  wire logic                       presetn,               // Async reset, active low
	input  wire logic [hdc_pkg::ADDR_W-1:0] paddr,                 // APB address
	input  wire logic                       psel,                  // APB select
	input  wire logic                       penable,               // APB enable
	input  wire logic                       pwrite,                // APB write
	input  wire logic [hdc_pkg::DATA_W-1:0] pwdata,                // APB write data
	output logic      [hdc_pkg::DATA_W-1:0] prdata,                // APB read data
	output logic                            pready,                // APB ready
	output logic                            pslverr,               // APB error
	input  wire logic                       lra_mode,              // LRA actuator selected
	input  wire logic                       closed_loop,           // Feedback loop active
	input  wire logic                       overdrive_phase,       // Overdrive in progress
	input  wire logic                       playback_go,           // Playback running
	input  wire logic                       trim_up,               // Loop asks longer drive
	input  wire logic                       trim_down,             // Loop asks shorter drive
	input  wire hdc_pkg::hdc_sample_t       sample_in,             // Input amplitude sample
	output logic                            overdrive_gain_boost,  // Boost bit
	output logic                            loop_gain_high,        // Raised loop gain
	output logic                            input_bias_enable,     // Bias on trigger pin
	output logic                            input_direction_select,// One: bidirectional
	output logic                            brake_gain_reduce,     // Brake stabiliser
	output logic      [1:0]                 sample_time_sel,       // Sampling time code
	output logic      [1:0]                 blanking_time_sel,     // Blanking time code
	output logic      [1:0]                 flyback_settle_period, // Dissipation time code
	output hdc_pkg::hdc_code_t              drive_time_code,       // Live drive time code
	output logic                            drive_tick,            // Drive period elapsed
	output hdc_pkg::hdc_level_t             drive_level,           // Signed output level
	output logic                            brake_active           // Negative drive
);
	import hdc_pkg::*;

	typedef struct packed {
		logic [7:0]        ctrl_one;
		logic [7:0]        ctrl_two;
		logic [DATA_W-1:0] rdata;
		logic              ready;
		logic              slverr;
		hdc_code_t         code;
		logic              go_d;
		logic              gain_high;
		logic              tick;
		hdc_level_t        level;
		logic              brake;
	} hdc_regs_state_t;

	hdc_regs_state_t r;
	hdc_regs_state_t next_r;
	hdc_timer_if     tif ();
	logic            setup;
	logic            access;
	logic            hit_one;
	logic            hit_two;

	// Bus phase decode
	assign setup   = psel && !penable;
	assign access  = psel && penable && r.ready;
	assign hit_one = (paddr == DRIVE_CONTROL_ONE_ADDR);
	assign hit_two = (paddr == DRIVE_CONTROL_TWO_ADDR);

	// Timer hookup
	assign tif.code     = r.code;
	assign tif.lra_mode = lra_mode;
	assign tif.run      = playback_go;

	hdc_drive_timer #(
		.LRA_STEP (LRA_STEP_CYCLES),
		.LRA_BASE (LRA_BASE_CYCLES),
		.ERM_STEP (ERM_STEP_CYCLES),
		.ERM_BASE (ERM_BASE_CYCLES)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (tif.timer)
	);

	// Next state
	always_comb begin
		next_r       = r;
		next_r.ready = 1'b0;
		// Answer in the cycle after setup
		if (setup) begin
			next_r.ready  = 1'b1;
			next_r.slverr = !(hit_one || hit_two);
			next_r.rdata  = '0;
			if (!pwrite && hit_one) begin
				next_r.rdata[7:0] = r.ctrl_one & CTRL_ONE_MASK;
			end else if (!pwrite && hit_two) begin
				next_r.rdata[7:0] = r.ctrl_two;
			end
		end
		// Write at the completing edge
		if (access && pwrite && hit_one) begin
			next_r.ctrl_one = pwdata[7:0] & CTRL_ONE_MASK;
		end
		if (access && pwrite && hit_two) begin
			next_r.ctrl_two = pwdata[7:0];
		end
		if (access) begin
			next_r.slverr = 1'b0;
		end
		// Seed drive time at playback start, then trim in LRA mode
		next_r.go_d = playback_go;
		if (!playback_go || (playback_go && !r.go_d) || !lra_mode) begin
			next_r.code = r.ctrl_one[DTIME_LSB +: DTIME_W];
		end else if (trim_up && !trim_down && r.code != 5'h1F) begin
			next_r.code = r.code + 5'h01;
		end else if (trim_down && !trim_up && r.code != 5'h00) begin
			next_r.code = r.code - 5'h01;
		end
		next_r.gain_high = r.ctrl_one[BOOST_BIT] && overdrive_phase;
		next_r.tick      = tif.tick;
		// Amplitude mapping
		if (!r.ctrl_two[DIR_BIT]) begin
			next_r.level = {1'b0, sample_in};
			next_r.brake = 1'b0;
		end else if (!sample_in[7] && closed_loop) begin
			next_r.level = '0;
			next_r.brake = 1'b0;
		end else begin
			next_r.level = {~sample_in[7], sample_in[6:0], 1'b0};
			next_r.brake = !sample_in[7];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r          <= '0;
			r.ctrl_one <= CTRL_ONE_RESET;
			r.ctrl_two <= CTRL_TWO_RESET;
			r.code     <= CTRL_ONE_RESET[DTIME_W-1:0];
		end else begin
			r <= next_r;
		end
	end

	// Outputs from state
	assign prdata                 = r.rdata;
	assign pready                 = r.ready;
	assign pslverr                = r.slverr;
	assign overdrive_gain_boost   = r.ctrl_one[BOOST_BIT];
	assign loop_gain_high         = r.gain_high;
	assign input_bias_enable      = r.ctrl_one[BIAS_BIT];
	assign input_direction_select = r.ctrl_two[DIR_BIT];
	assign brake_gain_reduce      = r.ctrl_two[BRAKE_BIT];
	assign sample_time_sel        = r.ctrl_two[SAMPLE_LSB +: 2];
	assign blanking_time_sel      = r.ctrl_two[BLANK_LSB +: 2];
	assign flyback_settle_period  = r.ctrl_two[SETTLE_LSB +: 2];
	assign drive_time_code        = r.code;
	assign drive_tick             = r.tick;
	assign drive_level            = r.level;
	assign brake_active           = r.brake;

endmodule : hdc_regs

//--- dv/hdc_regs_props.sv
// Purpose: Port checks of the drive control register bank
// Assumes: One pclk domain; APB answers after one access cycle
// Notes:   Bound to every instance of the bank
`timescale 1ns/100ps
module hdc_regs_props (
	input wire logic                       pclk,                   // Clock
	input wire logic                       presetn,                // Reset, active low
	input wire logic [hdc_pkg::ADDR_W-1:0] paddr,                  // Address
	input wire logic                       psel,                   // Select
	input wire logic                       penable,                // Enable
	input wire logic                       pwrite,                 // Write
	input wire logic [hdc_pkg::DATA_W-1:0] pwdata,                 // Write data
	input wire logic [hdc_pkg::DATA_W-1:0] prdata,                 // Read data
	input wire logic                       pready,                 // Ready
	input wire logic                       pslverr,                // Error
	input wire logic                       closed_loop,            // Loop closed
	input wire logic                       overdrive_phase,        // Overdrive
	input wire hdc_pkg::hdc_sample_t       sample_in,              // Amplitude in
	input wire logic                       overdrive_gain_boost,   // Boost bit
	input wire logic                       loop_gain_high,         // Raised gain
	input wire logic                       input_bias_enable,      // Bias bit
	input wire logic                       input_direction_select, // Direction bit
	input wire hdc_pkg::hdc_level_t        drive_level,            // Level out
	input wire logic                       brake_active            // Negative drive
);
	import hdc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Decode and transfer phases
	logic mapped;
	assign mapped = paddr == DRIVE_CONTROL_ONE_ADDR || paddr == DRIVE_CONTROL_TWO_ADDR;
	sequence s_setup; psel && !penable; endsequence
	sequence s_done; psel && penable && pready; endsequence
	chk_apb_answer: assert property (s_setup |=> s_done ##1 !pready)
		else $error("no single-cycle answer");
	chk_unmapped_err: assert property (s_done |-> pslverr == !mapped && (mapped || prdata == 0))
		else $error("error response wrong");
	chk_rsvd_read: assert property (s_done ##0 (!pwrite && paddr == DRIVE_CONTROL_ONE_ADDR)
		|-> prdata[7:5] == {overdrive_gain_boost, 1'b0, input_bias_enable}) else $error("read bad");
	chk_one_write: assert property (s_done ##0 (pwrite && paddr == DRIVE_CONTROL_ONE_ADDR)
		|=> {overdrive_gain_boost, input_bias_enable} == {$past(pwdata[7]), $past(pwdata[5])})
		else $error("first register write lost");
	chk_dir_write: assert property (s_done ##0 (pwrite && paddr == DRIVE_CONTROL_TWO_ADDR)
		|=> input_direction_select == $past(pwdata[7])) else $error("direction write lost");
	chk_boost_gain: assert property (1 |=> loop_gain_high == $past(overdrive_gain_boost && overdrive_phase))
		else $error("loop gain wrong");
	chk_uni_level: assert property (!input_direction_select |=> drive_level == {1'b0, $past(sample_in)})
		else $error("unidirectional level wrong");
	chk_bidir_open: assert property (input_direction_select && !closed_loop
		|=> drive_level == {~$past(sample_in[7]), $past(sample_in[6:0]), 1'b0})
		else $error("bidirectional level wrong");
	chk_bidir_closed: assert property (input_direction_select && closed_loop && !sample_in[7]
		|=> drive_level == 0) else $error("closed-loop low input drives");
	chk_brake_sign: assert property (brake_active == drive_level[8])
		else $error("brake flag wrong");
endmodule : hdc_regs_props
bind hdc_regs hdc_regs_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .closed_loop(closed_loop), .overdrive_phase(overdrive_phase),
	.sample_in(sample_in), .overdrive_gain_boost(overdrive_gain_boost),
	.loop_gain_high(loop_gain_high), .input_bias_enable(input_bias_enable),
	.input_direction_select(input_direction_select), .drive_level(drive_level),
	.brake_active(brake_active));

//--- dv/hdc_regs_test.sv
// Purpose: Self-checking bench of the drive control register bank
// Assumes: Timer counts shrunk to 4, 10, 8 and 20 cycles
// Notes:   Random traffic from an xorshift source seeded with 19
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module hdc_regs_test;
	import hdc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, seed = 19, rd;
	logic        pready, pslverr, lra_mode = 0, closed_loop = 0, overdrive_phase = 0;
	logic        playback_go = 0, trim_up = 0, trim_down = 0, boost, gain, bias, dir, tick, brk;
	logic [1:0]  settle, stime, btime;
	hdc_sample_t sample_in = 0;
	hdc_level_t  level, exp_lvl;
	hdc_code_t   code;
	logic        lvl_ok = 0, exp_gain = 0, bgr;
	logic [14:0] flds;
	int          err_total = 0, checked = 0, cyc = 0, m1 = 8'h93, m2 = 8'hF5;
	hdc_regs #(.LRA_STEP_CYCLES(4), .LRA_BASE_CYCLES(10), .ERM_STEP_CYCLES(8),
		.ERM_BASE_CYCLES(20)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .lra_mode, .closed_loop, .overdrive_phase, .playback_go,
		.trim_up, .trim_down, .sample_in, .overdrive_gain_boost(boost), .loop_gain_high(gain),
		.input_bias_enable(bias), .input_direction_select(dir), .brake_gain_reduce(bgr),
		.sample_time_sel(stime), .blanking_time_sel(btime), .flyback_settle_period(settle),
		.drive_time_code(code), .drive_tick(tick), .drive_level(level), .brake_active(brk));
	// Every register field output in one word, in register bit order
	assign flds = {boost, bias, code, dir, bgr, stime, btime, settle};
	// Clock source
	initial forever #2 pclk = ~pclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic wrap_up();
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// One APB transfer; the model follows a write at its completing edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
		if (w && a == DRIVE_CONTROL_ONE_ADDR) m1 = d[7:0] & CTRL_ONE_MASK;
		if (w && a == DRIVE_CONTROL_TWO_ADDR) m2 = d[7:0];
	endtask : apb
	task automatic rchk(input logic [7:0] a);
		apb(0, a, 0);
		if (a == DRIVE_CONTROL_ONE_ADDR) `CHK("ctrl_one", m1, {er, rd})
		else if (a == DRIVE_CONTROL_TWO_ADDR) `CHK("ctrl_two", m2, {er, rd})
		else `CHK("unmapped", 33'h1_0000_0000, {er, rd})
		`CHK("fields", {m1[7], m1[5], m1[4:0], m2[7:0]}, flds)
	endtask : rchk
	// One trim request, then the live code one edge after it lands
	task automatic trim(input logic u, input logic d, input logic [4:0] exp);
		{trim_up, trim_down} <= {u, d};
		@(posedge pclk);
		{trim_up, trim_down} <= 2'b00;
		@(posedge pclk);
		`CHK("trim", exp, code)
	endtask : trim
	// Cycles between two drive ticks
	task automatic gap(input int exp);
		int k;
		k = 0;
		do @(posedge pclk); while (tick !== 1'b1);
		do begin @(posedge pclk); k++; end while (tick !== 1'b1);
		`CHK("period", exp, k)
	endtask : gap
	// Timeout, random amplitude stimulus and cycle model of level, brake and gain
	always @(posedge pclk) begin
		cyc++;
		if (lvl_ok) begin
			`CHK("level", exp_lvl, level)
			`CHK("brake", exp_lvl[8], brk)
			`CHK("gain", exp_gain, gain)
		end
		if (!m2[7]) exp_lvl = {1'b0, sample_in};
		else if (closed_loop && !sample_in[7]) exp_lvl = 0;
		else exp_lvl = 9'(2 * (int'(sample_in) - 128));
		exp_gain = m1[7] && overdrive_phase;
		lvl_ok = presetn && pready !== 1'b1;
		seed = xs(seed);
		sample_in <= seed[9:2];
		overdrive_phase <= seed[0];
		// Open loop only while bidirectional, held closed across a direction write
		closed_loop <= seed[1] || !m2[7] || !dir || pready === 1'b1;
		// Timeout counts as a mismatch and closes the run
		if (cyc == 5000) begin
			err_total++;
			wrap_up();
		end
	end
	// Reset values, random register traffic, then drive timing
	initial begin
		logic [7:0] a;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		rchk(DRIVE_CONTROL_ONE_ADDR);
		rchk(DRIVE_CONTROL_TWO_ADDR);
		`CHK("code", 5'h13, code)
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			a = seed[1] ? seed[31:24] : seed[0] ? DRIVE_CONTROL_TWO_ADDR : DRIVE_CONTROL_ONE_ADDR;
			// Input is taken as analog throughout, so the bias bit may be set
			apb(1, a, seed);
			rchk(a);
		end
		apb(1, DRIVE_CONTROL_ONE_ADDR, 32'h0000_0002);
		playback_go <= 1;
		gap(20 + 2 * 8);
		playback_go <= 0;
		lra_mode <= 1;
		@(posedge pclk);
		playback_go <= 1;
		gap(10 + 2 * 4);
		`CHK("code", 5'h02, code)
		// Live trimming while playing in LRA mode, the lower clamp and a tie
		trim(1, 0, 5'h03);
		trim(0, 1, 5'h02);
		trim(1, 1, 5'h02);
		trim(0, 1, 5'h01);
		trim(0, 1, 5'h00);
		trim(0, 1, 5'h00);
		gap(10);
		// ERM ignores trims and follows the register
		lra_mode <= 0;
		trim(1, 0, 5'h02);
		wrap_up();
	end
endmodule : hdc_regs_test
